// File: hdl/t1_loopback_test_control.sv
/*
  Loopback and test control for a T1 to SDSL termination unit, with AHB-Lite registers.
  Assumes one 25 MHz clock, a bit per cycle on the DSX-1 stream, net_bit_en on the
  network stream, and one-cycle activation pulses from the carrier code detectors.
*/
// The AHB-Lite interface to the registers and the register addresses are this design's own decisions.
//
// Overview of operation
// - Terminal-side loopback returns DSX-1 receive to DSX-1 transmit before the framer.
// - Terminal-side loopback start refused while another loopback runs.
// - Remote loopback sends the Up or Down command ten seconds, then stops.
// - Remote command sending cannot be stopped manually; ten seconds always complete.
// - Remote loopback refused while any loopback or pattern test is active.
// - Both units send the 511 pattern with test lamps lit throughout.
// - Pattern test is no loopback; each unit generates and checks independently.
// - Initiator counts bit errors with elapsed time; clear command zeroes count while the test runs.
// - Lamp test blinks all lamps together once a second, then restores.
// - Enabled timeout ends any user test after configured minutes, ten by default.
// - Abort-all stops all user tests; completion shown only after all ended.
// - Abort-all leaves carrier-started loopbacks running until carrier releases.
// - Aborted tests involving the remote unit may run a few seconds longer.
// - Carrier line loopback returns signal unmodified, violations and overhead intact.
// - Carrier payload loopback regenerates overhead bits and removes bipolar violations.
// - Line loop by in-band or bit code; payload, remote by bit code only.
// - Remote carrier loopback loops at remote; local unit passes data back.
`timescale 1ns/1ps
module t1_loopback_test_control
  import t1lt_pkg::*;
#(
  parameter int unsigned CYCLES_PER_SEC = CYC_PER_SEC,
  parameter int unsigned NLED           = 8,
  parameter int unsigned ERRW           = 32
) (
  input  wire logic            core_clk,
  input  wire logic            rst_b,
  // AHB-Lite slave.
  input  wire logic            hsel,
  input  wire logic [31:0]     haddr,
  input  wire logic [1:0]      htrans,
  input  wire logic            hwrite,
  input  wire logic [2:0]      hsize,
  input  wire logic [31:0]     hwdata,
  input  wire logic            hready,
  output logic                 hreadyout,
  output logic                 hresp,
  output logic [31:0]          hrdata,
  // DSX-1 side.
  input  wire logic            dsx_rx_bit,
  input  wire logic            dsx_rx_bipolar_violation,
  input  wire logic            dsx_rx_overhead,
  input  wire logic            overhead_regen_bit,
  input  wire logic            framer_tx_bit,
  output logic                 framer_rx_bit,
  output logic                 dsx_tx_bit,
  output logic                 dsx_tx_bipolar_violation,
  // Network (DSL) side.
  input  wire logic            net_bit_en,
  input  wire logic            net_rx_bit,
  input  wire logic            framer_net_tx_bit,
  output logic                 net_tx_bit,
  output logic                 remote_cmd_send,
  output logic                 remote_cmd_up,
  output logic                 remote_carrier_loop,
  // Carrier activation and release pulses.
  input  wire logic            inband_line_up,
  input  wire logic            inband_line_down,
  input  wire logic            boc_line_up,
  input  wire logic            boc_line_down,
  input  wire logic            boc_payload_up,
  input  wire logic            boc_payload_down,
  input  wire logic            boc_remote_up,
  input  wire logic            boc_remote_down,
  // Front panel.
  input  wire logic [NLED-1:0] normal_leds,
  output logic [NLED-1:0]      leds,
  output logic                 test_led
);

  typedef struct packed {
    logic            wr_pend;
    logic [7:0]      wr_addr;
    logic [31:0]     rdata;
    logic [2:0]      ctrl;
    logic [7:0]      tmo_min;
    logic            dte;
    logic            nlp;
    logic            rmt_send;
    logic            rmt_up;
    logic [3:0]      rmt_sec;
    logic            pat;
    logic            lamp;
    logic            carr_line;
    logic            carr_pay;
    logic            carr_rmt;
    logic            abort_busy;
    logic            abort_done;
    logic            refused;
    logic [ERRW-1:0] errcnt;
    logic [31:0]     elapsed;
    logic [15:0]     test_sec;
    logic            dsx_tx;
    logic            dsx_cv;
    logic            net_tx;
    logic [NLED-1:0] led;
    logic            tled;
  } ctl_state_t;

  ctl_state_t q;
  ctl_state_t d;

  logic sec_pulse;
  logic blink_on;
  logic pat_tx;
  logic pat_err;

  second_tick #(
    .CYCLES    (CYCLES_PER_SEC)
  ) u_tick (
    .core_clk  (core_clk),
    .rst_b     (rst_b),
    .sec_pulse (sec_pulse),
    .blink_on  (blink_on)
  );

  prbs511_engine #(
    .LEN       (PRBS_LEN),
    .TAP       (PRBS_TAP)
  ) u_prbs (
    .core_clk  (core_clk),
    .rst_b     (rst_b),
    .enable    (q.pat),
    .bit_en    (net_bit_en),
    .rx_bit    (net_rx_bit),
    .tx_bit    (pat_tx),
    .bit_error (pat_err)
  );

  logic        addr_ok;
  logic        wr_now;
  logic [10:0] cmd;
  logic        any_loop;
  logic        user_active;
  logic        tmo_hit;
  logic [31:0] status;

  // A write lands in the data phase, one cycle after its address was taken.
  assign addr_ok = hsel & htrans[1] & hready;
  assign wr_now  = q.wr_pend & (q.wr_addr == OFS_CMD);
  assign cmd     = wr_now ? hwdata[10:0] : 11'h000;

  assign any_loop    = q.dte | q.nlp | q.rmt_send | q.carr_line | q.carr_pay | q.carr_rmt;
  assign user_active = q.dte | q.nlp | q.pat | q.lamp;
  assign tmo_hit     = q.ctrl[CTRL_TMO_EN] & user_active &
                       (q.test_sec >= 16'(q.tmo_min * 14'(SEC_PER_MIN)));

  always_comb begin
    status                = 32'h0000_0000;
    status[ST_DTE]        = q.dte;
    status[ST_NLP]        = q.nlp;
    status[ST_RMT_SEND]   = q.rmt_send;
    status[ST_PAT]        = q.pat;
    status[ST_LAMP]       = q.lamp;
    status[ST_CARR_LINE]  = q.carr_line;
    status[ST_CARR_PAY]   = q.carr_pay;
    status[ST_CARR_RMT]   = q.carr_rmt;
    status[ST_ABORT_BUSY] = q.abort_busy;
    status[ST_ABORT_DONE] = q.abort_done;
    status[ST_REFUSED]    = q.refused;
  end

  always_comb begin
    logic stop_all;
    logic refuse;
    stop_all = 1'b0;
    refuse   = 1'b0;
    d        = q;

    // Bus address phase: capture writes, prepare read data for the data phase.
    d.wr_pend = addr_ok & hwrite;
    if (addr_ok) begin
      d.wr_addr = haddr[7:0];
    end
    if (addr_ok && !hwrite) begin
      unique case (haddr[7:0])
        OFS_CTRL:    d.rdata = {29'h0000_0000, q.ctrl};
        OFS_STATUS:  d.rdata = status;
        OFS_ERRCNT:  d.rdata = 32'(q.errcnt);
        OFS_ELAPSED: d.rdata = q.elapsed;
        OFS_TIMEOUT: d.rdata = {24'h00_0000, q.tmo_min};
        default:     d.rdata = 32'h0000_0000;
      endcase
    end
    if (q.wr_pend && q.wr_addr == OFS_CTRL) begin
      d.ctrl = hwdata[2:0];
    end
    if (q.wr_pend && q.wr_addr == OFS_TIMEOUT) begin
      d.tmo_min = hwdata[7:0];
    end
    // Sticky flags clear by writing one; a same-cycle event below still wins.
    if (q.wr_pend && q.wr_addr == OFS_STATUS) begin
      if (hwdata[ST_ABORT_DONE]) begin
        d.abort_done = 1'b0;
      end
      if (hwdata[ST_REFUSED]) begin
        d.refused = 1'b0;
      end
    end

    // Terminal-side loopback.
    if (cmd[CMD_DTE_START]) begin
      if (any_loop && !q.dte) begin
        refuse = 1'b1;
      end else begin
        d.dte = 1'b1;
      end
    end
    if (cmd[CMD_DTE_STOP]) begin
      d.dte = 1'b0;
    end

    // Network line loopback.
    if (cmd[CMD_NLP_START]) begin
      if ((any_loop || q.pat) && !q.nlp) begin
        refuse = 1'b1;
      end else begin
        d.nlp = 1'b1;
      end
    end
    if (cmd[CMD_NLP_STOP]) begin
      d.nlp = 1'b0;
    end

    // Remote command sending: no stop command exists, it ends on its own count.
    if (cmd[CMD_RMT_SEND]) begin
      if (any_loop || q.pat) begin
        refuse = 1'b1;
      end else begin
        d.rmt_send = 1'b1;
        d.rmt_up   = q.ctrl[CTRL_SEND_UP];
        d.rmt_sec  = 4'h0;
      end
    end else if (q.rmt_send && sec_pulse) begin
      if (q.rmt_sec == 4'(REMOTE_SEND_S - 1)) begin
        d.rmt_send = 1'b0;
      end else begin
        d.rmt_sec = q.rmt_sec + 4'h1;
      end
    end

    // Pattern test with error count and elapsed seconds.
    if (cmd[CMD_PAT_START] && !q.pat) begin
      if (any_loop) begin
        refuse = 1'b1;
      end else begin
        d.pat     = 1'b1;
        d.errcnt  = '0;
        d.elapsed = 32'h0000_0000;
      end
    end
    if (cmd[CMD_PAT_STOP]) begin
      d.pat = 1'b0;
    end
    if (q.pat) begin
      if (sec_pulse) begin
        d.elapsed = q.elapsed + 32'h0000_0001;
      end
      // Clear then count, so an error in the clearing cycle is kept; saturates.
      if (cmd[CMD_ERR_CLEAR]) begin
        d.errcnt = ERRW'(pat_err);
      end else if (pat_err && q.errcnt != '1) begin
        d.errcnt = q.errcnt + ERRW'(1);
      end
    end

    // Lamp test.
    if (cmd[CMD_LAMP_START]) begin
      d.lamp = 1'b1;
    end
    if (cmd[CMD_LAMP_STOP]) begin
      d.lamp = 1'b0;
    end

    // Timeout: one clock of seconds runs while any user test runs.
    if (!user_active) begin
      d.test_sec = 16'h0000;
    end else if (sec_pulse && q.test_sec != 16'hFFFF) begin
      d.test_sec = q.test_sec + 16'h0001;
    end

    // Abort-all waits for the remote send window, the only test it cannot cut short.
    if (cmd[CMD_ABORT_ALL]) begin
      d.abort_busy = 1'b1;
    end
    stop_all = tmo_hit | cmd[CMD_ABORT_ALL] | q.abort_busy;
    if (stop_all) begin
      d.dte  = 1'b0;
      d.nlp  = 1'b0;
      d.pat  = 1'b0;
      d.lamp = 1'b0;
    end
    if (q.abort_busy && !user_active && !q.rmt_send) begin
      d.abort_busy = 1'b0;
      d.abort_done = 1'b1;
    end
    if (refuse) begin
      d.refused = 1'b1;
    end

    // Carrier-started loopbacks: only the carrier's release ends them.
    if (inband_line_up || boc_line_up) begin
      d.carr_line = 1'b1;
    end else if (inband_line_down || boc_line_down) begin
      d.carr_line = 1'b0;
    end
    if (boc_payload_up) begin
      d.carr_pay = 1'b1;
    end else if (boc_payload_down) begin
      d.carr_pay = 1'b0;
    end
    if (boc_remote_up) begin
      d.carr_rmt = 1'b1;
    end else if (boc_remote_down) begin
      d.carr_rmt = 1'b0;
    end

    // DSX-1 transmit selection.
    if (q.dte || q.carr_line) begin
      d.dsx_tx  = dsx_rx_bit;
      d.dsx_cv  = dsx_rx_bipolar_violation;
    end else if (q.carr_pay) begin
      d.dsx_tx  = dsx_rx_overhead ? overhead_regen_bit : dsx_rx_bit;
      d.dsx_cv  = 1'b0;
    end else if (q.carr_rmt && q.ctrl[CTRL_RMT_CARR]) begin
      d.dsx_tx  = net_rx_bit;
      d.dsx_cv  = 1'b0;
    end else begin
      d.dsx_tx  = framer_tx_bit;
      d.dsx_cv  = 1'b0;
    end

    // Network transmit selection.
    if (q.nlp) begin
      d.net_tx = net_rx_bit;
    end else if (q.pat) begin
      d.net_tx = pat_tx;
    end else begin
      d.net_tx = framer_net_tx_bit;
    end

    // Lamps: all blink in step during the lamp test, otherwise normal display.
    d.led  = q.lamp ? {NLED{blink_on}} : normal_leds;
    d.tled = q.lamp ? blink_on : (any_loop | q.pat);
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      q         <= '0;
      q.ctrl    <= CTRL_RST;
      q.tmo_min <= TIMEOUT_MIN_RST;
    end else begin
      q <= d;
    end
  end

  // Zero-wait-state slave; hsize is not checked because only whole words are used.
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = q.rdata;

  assign framer_rx_bit            = dsx_rx_bit;
  assign dsx_tx_bit               = q.dsx_tx;
  assign dsx_tx_bipolar_violation = q.dsx_cv;
  assign net_tx_bit               = q.net_tx;
  assign remote_cmd_send          = q.rmt_send;
  assign remote_cmd_up            = q.rmt_up;
  assign remote_carrier_loop      = q.carr_rmt & q.ctrl[CTRL_RMT_CARR];
  assign leds                     = q.led;
  assign test_led                 = q.tled;

endmodule : t1_loopback_test_control

// File: hdl/t1lt_pkg.sv
/*
  Shared constants for the T1 loopback and test control block: register offsets,
  register field positions, reset values and timing counts.
  Assumes a 25 MHz core clock and a 32-bit AHB-Lite register bus.
*/
package t1lt_pkg;

  // Clock and timing.
  localparam int unsigned CLK_PERIOD_NS   = 40;
  localparam int unsigned TICK_S          = 1;
  localparam int unsigned NS_PER_S        = 1_000_000_000;
  localparam int unsigned CYC_PER_SEC     = TICK_S * NS_PER_S / CLK_PERIOD_NS;
  localparam int unsigned REMOTE_SEND_S   = 10;
  localparam int unsigned SEC_PER_MIN     = 60;
  localparam logic [7:0]  TIMEOUT_MIN_RST = 8'h0A;

  // Pattern generator shape.
  localparam int unsigned PRBS_LEN = 9;
  localparam int unsigned PRBS_TAP = 5;

  // Register byte offsets.
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_CMD     = 8'h04;
  localparam logic [7:0] OFS_STATUS  = 8'h08;
  localparam logic [7:0] OFS_ERRCNT  = 8'h0C;
  localparam logic [7:0] OFS_ELAPSED = 8'h10;
  localparam logic [7:0] OFS_TIMEOUT = 8'h14;

  // Control register fields and reset value.
  localparam int unsigned CTRL_TMO_EN     = 0;
  localparam int unsigned CTRL_RMT_CARR   = 1;
  localparam int unsigned CTRL_SEND_UP    = 2;
  localparam logic [2:0]  CTRL_RST        = 3'h1;

  // Command register bits, each a one-shot on write.
  localparam int unsigned CMD_DTE_START   = 0;
  localparam int unsigned CMD_DTE_STOP    = 1;
  localparam int unsigned CMD_NLP_START   = 2;
  localparam int unsigned CMD_NLP_STOP    = 3;
  localparam int unsigned CMD_RMT_SEND    = 4;
  localparam int unsigned CMD_PAT_START   = 5;
  localparam int unsigned CMD_PAT_STOP    = 6;
  localparam int unsigned CMD_LAMP_START  = 7;
  localparam int unsigned CMD_LAMP_STOP   = 8;
  localparam int unsigned CMD_ABORT_ALL   = 9;
  localparam int unsigned CMD_ERR_CLEAR   = 10;

  // Status register bits.
  localparam int unsigned ST_DTE          = 0;
  localparam int unsigned ST_NLP          = 1;
  localparam int unsigned ST_RMT_SEND     = 2;
  localparam int unsigned ST_PAT          = 3;
  localparam int unsigned ST_LAMP         = 4;
  localparam int unsigned ST_CARR_LINE    = 5;
  localparam int unsigned ST_CARR_PAY     = 6;
  localparam int unsigned ST_CARR_RMT     = 7;
  localparam int unsigned ST_ABORT_BUSY   = 8;
  localparam int unsigned ST_ABORT_DONE   = 9;
  localparam int unsigned ST_REFUSED      = 10;

endpackage : t1lt_pkg

// File: hdl/second_tick.sv
/*
  Free-running one-second tick and a 50 percent blink phase derived from it.
  Assumes one clock; CYCLES is the number of core clocks in one second.
*/
`timescale 1ns/1ps
module second_tick
  import t1lt_pkg::*;
#(
  parameter int unsigned CYCLES = CYC_PER_SEC
) (
  input  wire logic core_clk,
  input  wire logic rst_b,
  output logic      sec_pulse,
  output logic      blink_on
);

  localparam int unsigned W = $clog2(CYCLES);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         pulse;
    logic         blink;
  } tick_state_t;

  tick_state_t q;
  tick_state_t d;

  always_comb begin
    d       = q;
    d.pulse = 1'b0;
    if (q.cnt == W'(CYCLES - 1)) begin
      d.cnt   = '0;
      d.pulse = 1'b1;
    end else begin
      d.cnt = q.cnt + W'(1);
    end
    d.blink = (d.cnt < W'(CYCLES / 2));
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign sec_pulse = q.pulse;
  assign blink_on  = q.blink;

endmodule : second_tick

// File: hdl/prbs511_engine.sv
/*
  511 pattern generator and self-synchronising checker.
  Assumes bit_en marks one bit time on the network stream; enable low holds both idle.
*/
`timescale 1ns/1ps
module prbs511_engine
  import t1lt_pkg::*;
#(
  parameter int unsigned LEN = PRBS_LEN,
  parameter int unsigned TAP = PRBS_TAP
) (
  input  wire logic core_clk,
  input  wire logic rst_b,
  input  wire logic enable,
  input  wire logic bit_en,
  input  wire logic rx_bit,
  output logic      tx_bit,
  output logic      bit_error
);

  typedef struct packed {
    logic [LEN-1:0] gen;
    logic [LEN-1:0] chk;
    logic [3:0]     fill;
    logic           tx;
    logic           err;
  } prbs_state_t;

  prbs_state_t q;
  prbs_state_t d;

  always_comb begin
    d     = q;
    d.err = 1'b0;
    if (!enable) begin
      d.gen  = '1;
      d.chk  = '0;
      d.fill = '0;
      d.tx   = 1'b0;
    end else if (bit_en) begin
      d.tx  = q.gen[LEN-1];
      d.gen = {q.gen[LEN-2:0], q.gen[LEN-1] ^ q.gen[TAP-1]};
      // The checker predicts from received bits only, so it locks within LEN bits.
      if (q.fill == 4'(LEN)) begin
        d.err = rx_bit != (q.chk[LEN-1] ^ q.chk[TAP-1]);
      end else begin
        d.fill = q.fill + 4'h1;
      end
      d.chk = {q.chk[LEN-2:0], rx_bit};
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign tx_bit    = q.tx;
  assign bit_error = q.err;

endmodule : prbs511_engine

// File: verif/t1_loopback_test_control_sva.sv
/*
  Port checker for the loopback and test control block.
  Assumes a bind into the top module, ports matched by name.
*/
`timescale 1ns/1ps
module t1_loopback_test_control_sva
  import t1lt_pkg::*;
#(
  parameter int unsigned CYCLES_PER_SEC = CYC_PER_SEC
) (
  input logic        core_clk,
  input logic        rst_b,
  input logic        hsel,
  input logic [31:0] haddr,
  input logic [1:0]  htrans,
  input logic        hwrite,
  input logic [31:0] hwdata,
  input logic        hready,
  input logic        hreadyout,
  input logic        hresp,
  input logic        dsx_rx_bit,
  input logic        dsx_rx_bipolar_violation,
  input logic        dsx_rx_overhead,
  input logic        overhead_regen_bit,
  input logic        framer_rx_bit,
  input logic        dsx_tx_bit,
  input logic        dsx_tx_bipolar_violation,
  input logic        net_rx_bit,
  input logic        remote_cmd_send,
  input logic        remote_cmd_up,
  input logic        remote_carrier_loop,
  input logic        inband_line_up,
  input logic        inband_line_down,
  input logic        boc_line_up,
  input logic        boc_line_down,
  input logic        boc_payload_up,
  input logic        boc_payload_down,
  input logic        boc_remote_up,
  input logic        boc_remote_down
);
  localparam int unsigned SEND_MIN = (REMOTE_SEND_S - 1) * CYCLES_PER_SEC;
  localparam int unsigned SEND_MAX = REMOTE_SEND_S * CYCLES_PER_SEC + 1;
  logic        line_q, pay_q, rmt_q, cmd_wr_q, dte_seen_q;
  int unsigned send_cnt_q;

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      {line_q, pay_q, rmt_q, cmd_wr_q, dte_seen_q} <= 5'h00;
      send_cnt_q <= 0;
    end else begin
      line_q <= (inband_line_up || boc_line_up) || (line_q && !inband_line_down && !boc_line_down);
      pay_q <= boc_payload_up || (pay_q && !boc_payload_down);
      rmt_q <= boc_remote_up || (rmt_q && !boc_remote_down);
      cmd_wr_q <= hsel && htrans[1] && hready && hwrite && haddr[7:0] == OFS_CMD;
      dte_seen_q <= dte_seen_q || (cmd_wr_q && hwdata[CMD_DTE_START]);
      send_cnt_q <= remote_cmd_send ? send_cnt_q + 1 : 0;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus not OKAY");
  a_framer_copy: assert property (framer_rx_bit == dsx_rx_bit)
    else $error("framer copy differs");
  a_line_raw: assert property (line_q && $past(line_q, 2) |->
    dsx_tx_bit == $past(dsx_rx_bit) && dsx_tx_bipolar_violation == $past(dsx_rx_bipolar_violation))
    else $error("line loop altered");
  a_pay_regen: assert property (pay_q && $past(pay_q, 2) && !line_q && !$past(line_q, 2)
    && !dte_seen_q |-> dsx_tx_bit == ($past(dsx_rx_overhead) ? $past(overhead_regen_bit)
    : $past(dsx_rx_bit))) else $error("overhead not regenerated");
  a_pay_no_bpv: assert property (pay_q && $past(pay_q, 2) && !line_q && !dte_seen_q
    |-> !dsx_tx_bipolar_violation) else $error("violation passed");
  a_rmt_path: assert property (remote_carrier_loop && $past(remote_carrier_loop) && !line_q
    && !$past(line_q, 2) && !pay_q && !$past(pay_q, 2) && !dte_seen_q
    |-> dsx_tx_bit == $past(net_rx_bit)) else $error("remote data not returned");
  a_rmt_cause: assert property (remote_carrier_loop |-> rmt_q || $past(rmt_q))
    else $error("remote loop uncaused");
  a_send_len: assert property ($fell(remote_cmd_send) |-> send_cnt_q >= SEND_MIN)
    else $error("window short");
  a_send_max: assert property (remote_cmd_send |-> send_cnt_q <= SEND_MAX)
    else $error("window long");
  a_up_hold: assert property (remote_cmd_send && $past(remote_cmd_send) |->
    $stable(remote_cmd_up)) else $error("command changed");
endmodule : t1_loopback_test_control_sva

// File: verif/peer_unit_model.sv
/*
  Far-end unit on the DSL side: pattern source and line loop.
  Assumes the block's network stream and remote command outputs.
*/
`timescale 1ns/1ps
module peer_unit_model #(
  parameter int unsigned TMO_CYC = 100000
) (
  input  logic core_clk,
  input  logic rst_b,
  input  logic net_tx_bit,
  input  logic remote_cmd_send,
  input  logic remote_cmd_up,
  input  logic inject,
  output logic net_bit_en,
  output logic net_rx_bit,
  output logic looped,
  output logic lamp
);
  logic [8:0]  lfsr_q;
  int unsigned loop_cyc_q;
  logic        fb;
  assign fb = lfsr_q[8] ^ lfsr_q[4];
  assign lamp = looped;
  // A bit time every other cycle, so the far side runs slower.
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      {net_bit_en, net_rx_bit, looped} <= 3'h0;
      loop_cyc_q <= 0;
      lfsr_q <= 9'h1FF;
    end else begin
      net_bit_en <= !net_bit_en;
      loop_cyc_q <= looped ? loop_cyc_q + 1 : 0;
      if (net_bit_en) begin
        lfsr_q <= {lfsr_q[7:0], fb};
        net_rx_bit <= looped ? net_tx_bit : fb ^ inject;
      end
      if (remote_cmd_send) begin
        looped <= remote_cmd_up;
      end else if (loop_cyc_q >= TMO_CYC) begin
        looped <= 1'b0;
      end
    end
  end
endmodule : peer_unit_model

// File: verif/t1_loopback_test_control_tb.sv
/*
  Self-checking bench for the loopback and test control block.
  Assumes the checker and peer model compile first; a second is CPS cycles.
*/
`timescale 1ns/1ps
module t1_loopback_test_control_tb;
  import t1lt_pkg::*;
  localparam int unsigned CPS = 20;
  localparam int unsigned LIMIT = 20000;
  logic        core_clk, rst_b, hsel, hwrite, inject;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        hreadyout, hresp, framer_rx_bit, dsx_tx_bit, dsx_tx_bipolar_violation;
  logic        dsx_rx_bit, dsx_rx_bipolar_violation, dsx_rx_overhead, overhead_regen_bit;
  logic        framer_tx_bit, framer_net_tx_bit, net_tx_bit, test_led, looped;
  logic        remote_cmd_send, remote_cmd_up, remote_carrier_loop, net_bit_en, net_rx_bit;
  logic [7:0]  normal_leds, leds, car, n;
  wire logic   hready = hreadyout;
  wire logic   inband_line_up, inband_line_down, boc_line_up, boc_line_down;
  wire logic   boc_payload_up, boc_payload_down, boc_remote_up, boc_remote_down;
  int          bad_count, checks_done, cyc, tog;
  assign {inband_line_up, inband_line_down, boc_line_up, boc_line_down,
          boc_payload_up, boc_payload_down, boc_remote_up, boc_remote_down} = car;

  t1_loopback_test_control #(.CYCLES_PER_SEC(CPS)) i_t1_loopback_test_control (.*);
  peer_unit_model i_peer_unit_model (.*, .lamp());

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    dsx_rx_bit <= cyc[0] ^ cyc[3];
    dsx_rx_bipolar_violation <= cyc[2:0] == 3'h5;
    dsx_rx_overhead <= cyc[3:0] == 4'h0;
    overhead_regen_bit <= cyc[1];
    framer_tx_bit <= cyc[2];
    framer_net_tx_bit <= cyc[1] ^ cyc[4];
    normal_leds <= cyc[10:3];
    if (cyc == LIMIT) begin
      bad_count++;
      results();
    end
  end

  task results;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : results

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
           output logic [31:0] rd);
    @(posedge core_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= 32'(a);
    hwrite <= w;
    do @(posedge core_clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge core_clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : bus

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask : wr

  task rchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    chk(x, exp);
  endtask : rchk

  task st(input logic [31:0] exp, input logic clr);
    rchk(OFS_STATUS, exp);
    if (clr) begin
      wr(OFS_STATUS, 32'h600);
    end
  endtask : st

  task cmd(input int b);
    wr(OFS_CMD, 32'h1 << b);
  endtask : cmd

  task pulse(input int i);
    @(posedge core_clk);
    car <= 8'h01 << i;
    @(posedge core_clk);
    car <= 8'h00;
    repeat (20) @(posedge core_clk);
  endtask : pulse

  task pathchk(input logic [2:0] m);
    logic [2:0] b;
    repeat (8) begin
      @(posedge core_clk);
      b = {dsx_rx_bit, dsx_rx_bipolar_violation, net_rx_bit};
      @(posedge core_clk);
      chk({29'h0, m & {dsx_tx_bit, dsx_tx_bipolar_violation, net_tx_bit}}, {29'h0, m & b});
    end
  endtask : pathchk

  initial begin
    {rst_b, hsel, hwrite, inject, haddr, hwdata, htrans, car, cyc} = '0;
    {dsx_rx_bit, dsx_rx_bipolar_violation, dsx_rx_overhead, overhead_regen_bit} = '0;
    {framer_tx_bit, framer_net_tx_bit, normal_leds, bad_count, checks_done} = '0;
    hsize = 3'h2;
    repeat (12) @(posedge core_clk);
    rst_b <= 1'b1;
    rchk(OFS_CTRL, 32'h1);
    rchk(OFS_TIMEOUT, 32'hA);
    st(32'h0, 1'b0);
    rchk(8'h1C, 32'h0);
    pulse(7);
    st(32'h20, 1'b0);
    pathchk(3'b110);
    pulse(6);
    pulse(5);
    cmd(CMD_LAMP_START);
    cmd(CMD_ABORT_ALL);
    st(32'h220, 1'b1);
    pulse(4);
    pulse(3);
    st(32'h40, 1'b0);
    pulse(2);
    wr(OFS_CTRL, 32'h3);
    pulse(1);
    st(32'h80, 1'b0);
    chk(remote_carrier_loop, 1);
    pulse(0);
    wr(OFS_CTRL, 32'h1);
    cmd(CMD_NLP_START);
    cmd(CMD_DTE_START);
    st(32'h402, 1'b1);
    cmd(CMD_RMT_SEND);
    st(32'h402, 1'b1);
    cmd(CMD_NLP_STOP);
    wr(OFS_CTRL, 32'h5);
    wr(OFS_CMD, 32'h90);
    @(posedge core_clk);
    chk({remote_cmd_send, remote_cmd_up}, 2'b11);
    cmd(CMD_ABORT_ALL);
    st(32'h104, 1'b0);
    repeat (10 * CPS + 20) @(posedge core_clk);
    st(32'h200, 1'b1);
    chk(looped, 1);
    wr(OFS_CTRL, 32'h1);
    cmd(CMD_RMT_SEND);
    repeat (10 * CPS + 20) @(posedge core_clk);
    chk(looped, 0);
    cmd(CMD_PAT_START);
    repeat (100) @(posedge core_clk);
    chk(test_led, 1);
    rchk(OFS_ERRCNT, 32'h0);
    cmd(CMD_RMT_SEND);
    st(32'h408, 1'b1);
    @(posedge core_clk);
    inject <= 1'b1;
    repeat (2) @(posedge core_clk);
    inject <= 1'b0;
    repeat (60) @(posedge core_clk);
    rchk(OFS_ERRCNT, 32'h3);
    bus(1'b0, OFS_ELAPSED, 32'h0, r);
    chk(r != 0, 1);
    cmd(CMD_ERR_CLEAR);
    rchk(OFS_ERRCNT, 32'h0);
    cmd(CMD_PAT_STOP);
    wr(OFS_TIMEOUT, 32'h1);
    cmd(CMD_LAMP_START);
    tog = 0;
    @(posedge core_clk);
    repeat (40) begin
      @(posedge core_clk);
      chk(leds === {8{test_led}}, 1);
      tog += int'(test_led !== leds[0] || leds !== n);
      n = leds;
    end
    chk(tog >= 3, 1);
    repeat (1000) @(posedge core_clk);
    st(32'h10, 1'b0);
    repeat (250) @(posedge core_clk);
    st(32'h0, 1'b0);
    @(posedge core_clk);
    n = normal_leds;
    @(posedge core_clk);
    chk(leds, n);
    cmd(CMD_DTE_START);
    st(32'h1, 1'b0);
    pathchk(3'b110);
    cmd(CMD_DTE_STOP);
    results();
  end
endmodule : t1_loopback_test_control_tb

bind t1_loopback_test_control t1_loopback_test_control_sva #(
  .CYCLES_PER_SEC(CYCLES_PER_SEC)
) i_t1_loopback_test_control_sva (.*);
